// ---- inc/dpram_host_cfg.svh ----
// Notes on behaviour
// - Read/write stays high for the whole of every read cycle.
// - Address is presented before chip select falls on a read.
// - Read/write is high whenever the address lines change.
// - The controller never drives data while the device may drive read data.
// - Chip select stays high through flag write and flag read-back cycles.
`ifndef DPRAM_HOST_CFG_SVH
`define DPRAM_HOST_CFG_SVH

`define CLK_PERIOD_NS   10
`define T_ACCESS_NS     20
`define T_WPULSE_NS     15
`define SYNC_STAGES     2
`define ACC_CYCLES      ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WP_CYCLES       ((`T_WPULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define REG_CTRL        3'h0
`define REG_ADDR        3'h1
`define REG_WDATA       3'h2
`define REG_STATUS      3'h3
`define REG_RDATA       3'h4

`define CTRL_START_BIT  0
`define CTRL_OP_LSB     1
`define CTRL_UPPER_BIT  3
`define CTRL_LOWER_BIT  4
`define CTRL_RESET      5'h18

`define ST_BUSY_BIT     0
`define ST_DONE_BIT     1
`define ST_STALL_BIT    2

`define ADDR_W          14
`define DATA_W          16

`endif

// ---- inc/dpram_host_pkg.sv ----
package dpram_host_pkg;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_SETUP  = 3'b001,
      ST_WR_ARM = 3'b010,
      ST_PULSE  = 3'b011,
      ST_END    = 3'b100,
      ST_REC    = 3'b101
   } seq_state_t;

   typedef enum logic [1:0] {
      OP_RAM_RD = 2'b00,
      OP_RAM_WR = 2'b01,
      OP_SEM_RD = 2'b10,
      OP_SEM_WR = 2'b11
   } port_op_t;

endpackage

// ---- src/dpram_port_host.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dpram_host_cfg.svh"

module dpram_port_host
   import dpram_host_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  resetn,
   input  wire logic [2:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   output logic      [`ADDR_W-1:0]    mem_addr,
   output logic                       chip_sel_n,
   output logic                       read_write,
   output logic                       out_en_n,
   output logic                       upper_lane_sel_n,
   output logic                       lower_lane_sel_n,
   output logic                       flag_space_sel_n,
   input  wire logic [`DATA_W-1:0]    data_i,
   output logic      [`DATA_W-1:0]    data_o,
   output logic      [1:0]            data_oe_n,
   input  wire logic                  busy_n
);

   // Read waits out the access time plus the data synchroniser
   localparam logic [3:0] RD_WAIT = 4'(`ACC_CYCLES + `SYNC_STAGES);
   // Pulse outlasts the busy synchroniser so an inhibit is always seen
   localparam logic [3:0] WR_WAIT = 4'(`WP_CYCLES + `SYNC_STAGES);

   function automatic logic is_write_op(input port_op_t op);
      is_write_op = (op == OP_RAM_WR) || (op == OP_SEM_WR);
   endfunction

   function automatic logic is_flag_op(input port_op_t op);
      is_flag_op = (op == OP_SEM_RD) || (op == OP_SEM_WR);
   endfunction

   // Pin synchronisers: first stage is read by the second only
   logic [`DATA_W-1:0] din_s1_q;
   logic [`DATA_W-1:0] din_s2_q;
   logic               busy_s1_q;
   logic               busy_s2_q;

   seq_state_t         state_q,     state_d;
   port_op_t           op_q,        op_d;
   logic [3:0]         cnt_q,       cnt_d;
   logic [4:0]         ctrl_q,      ctrl_d;
   logic [`ADDR_W-1:0] addr_reg_q,  addr_reg_d;
   logic [`DATA_W-1:0] wdata_q,     wdata_d;
   logic [`DATA_W-1:0] rdata_q,     rdata_d;
   logic               done_q,      done_d;
   logic               stall_q,     stall_d;
   logic [31:0]        rd_q,        rd_d;
   logic               wait_q,      wait_d;
   logic [`ADDR_W-1:0] pa_q,        pa_d;
   logic               ce_q,        ce_d;
   logic               rw_q,        rw_d;
   logic               oe_q,        oe_d;
   logic               ub_q,        ub_d;
   logic               lb_q,        lb_d;
   logic               sem_q,       sem_d;
   logic [`DATA_W-1:0] dq_q,        dq_d;
   logic [1:0]         doe_q,       doe_d;

   logic acc_wr;
   logic start;
   logic busy_now;

   assign busy_now = (state_q != ST_IDLE);
   assign acc_wr   = avs_write && !wait_q;
   assign start    = acc_wr && (avs_address == `REG_CTRL)
                     && avs_writedata[`CTRL_START_BIT] && !busy_now;

   always_comb begin
      // Register file
      // Waitrequest drops for exactly one cycle per access
      wait_d     = !((avs_read || avs_write) && wait_q);
      ctrl_d     = ctrl_q;
      addr_reg_d = addr_reg_q;
      wdata_d    = wdata_q;
      rd_d       = rd_q;
      // Registers are frozen while an access is on the pins
      if (acc_wr && !busy_now) begin
         if (avs_address == `REG_CTRL) begin
            ctrl_d = {avs_writedata[4:1], 1'b0};
         end else if (avs_address == `REG_ADDR) begin
            addr_reg_d = avs_writedata[`ADDR_W-1:0];
         end else if (avs_address == `REG_WDATA) begin
            wdata_d = avs_writedata[`DATA_W-1:0];
         end
      end
      if (avs_read && wait_q) begin
         if (avs_address == `REG_CTRL) begin
            rd_d = {27'h0, ctrl_q};
         end else if (avs_address == `REG_ADDR) begin
            rd_d = {18'h0, addr_reg_q};
         end else if (avs_address == `REG_WDATA) begin
            rd_d = {16'h0, wdata_q};
         end else if (avs_address == `REG_STATUS) begin
            rd_d = {29'h0, stall_q, done_q, busy_now};
         end else if (avs_address == `REG_RDATA) begin
            rd_d = {16'h0, rdata_q};
         end else begin
            rd_d = 32'h0;
         end
      end
   end

   always_comb begin
      // Port sequencer
      state_d = state_q;
      op_d    = op_q;
      cnt_d   = cnt_q;
      rdata_d = rdata_q;
      done_d  = done_q;
      stall_d = stall_q;
      pa_d    = pa_q;
      ce_d    = ce_q;
      rw_d    = rw_q;
      oe_d    = oe_q;
      ub_d    = ub_q;
      lb_d    = lb_q;
      sem_d   = sem_q;
      dq_d    = dq_q;
      doe_d   = doe_q;
      case (state_q)
         ST_IDLE: begin
            if (start) begin
               op_d    = port_op_t'(avs_writedata[`CTRL_OP_LSB +: 2]);
               done_d  = 1'b0;
               stall_d = 1'b0;
               pa_d    = addr_reg_q;
               rw_d    = 1'b1;
               state_d = ST_SETUP;
               // A RAM access with no lane would select the chip for nothing
               if (!is_flag_op(op_d) && !avs_writedata[`CTRL_UPPER_BIT]
                   && !avs_writedata[`CTRL_LOWER_BIT]) begin
                  done_d  = 1'b1;
                  state_d = ST_IDLE;
               end
            end
         end
         ST_SETUP: begin
            if (is_write_op(op_q)) begin
               // Read/write falls before the select so the device stays off
               rw_d  = 1'b0;
               oe_d  = 1'b1;
               dq_d  = is_flag_op(op_q) ? {{(`DATA_W-1){1'b1}}, wdata_q[0]} : wdata_q;
               doe_d = is_flag_op(op_q) ? 2'b00
                       : {!ctrl_q[`CTRL_UPPER_BIT], !ctrl_q[`CTRL_LOWER_BIT]};
               state_d = ST_WR_ARM;
            end else begin
               oe_d = 1'b0;
               cnt_d = RD_WAIT;
               state_d = ST_PULSE;
               if (is_flag_op(op_q)) begin
                  sem_d = 1'b0;
               end else begin
                  ce_d = 1'b0;
                  ub_d = !ctrl_q[`CTRL_UPPER_BIT];
                  lb_d = !ctrl_q[`CTRL_LOWER_BIT];
               end
            end
         end
         ST_WR_ARM: begin
            cnt_d   = WR_WAIT;
            state_d = ST_PULSE;
            if (is_flag_op(op_q)) begin
               sem_d = 1'b0;
            end else begin
               ce_d = 1'b0;
               ub_d = !ctrl_q[`CTRL_UPPER_BIT];
               lb_d = !ctrl_q[`CTRL_LOWER_BIT];
            end
         end
         ST_PULSE: begin
            if (is_write_op(op_q) && !busy_s2_q) begin
               // Inhibited write: restart the full pulse after busy clears
               cnt_d   = WR_WAIT;
               stall_d = 1'b1;
            end else if (cnt_q > 4'h1) begin
               cnt_d = cnt_q - 4'h1;
            end else begin
               if (!is_write_op(op_q)) begin
                  rdata_d = is_flag_op(op_q) ? {{(`DATA_W-1){1'b0}}, din_s2_q[0]}
                            : din_s2_q;
               end
               ce_d  = 1'b1;
               sem_d = 1'b1;
               ub_d  = 1'b1;
               lb_d  = 1'b1;
               oe_d  = 1'b1;
               state_d = ST_END;
            end
         end
         ST_END: begin
            rw_d  = 1'b1;
            doe_d = 2'b11;
            state_d = ST_REC;
         end
         ST_REC: begin
            // Turnaround cycle lets the device drivers float first
            done_d  = 1'b1;
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Synchronisers
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         din_s1_q  <= 16'h0;
         din_s2_q  <= 16'h0;
         // Released level, so no stall is seen straight after reset
         busy_s1_q <= 1'b1;
         busy_s2_q <= 1'b1;
      end else begin
         din_s1_q  <= data_i;
         din_s2_q  <= din_s1_q;
         busy_s1_q <= busy_n;
         busy_s2_q <= busy_s1_q;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q     <= `CTRL_RESET;
         addr_reg_q <= 14'h0;
         wdata_q    <= 16'h0;
         rd_q       <= 32'h0;
         wait_q     <= 1'b1;
      end else begin
         ctrl_q     <= ctrl_d;
         addr_reg_q <= addr_reg_d;
         wdata_q    <= wdata_d;
         rd_q       <= rd_d;
         wait_q     <= wait_d;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         op_q    <= OP_RAM_RD;
         cnt_q   <= 4'h0;
         rdata_q <= 16'h0;
         done_q  <= 1'b0;
         stall_q <= 1'b0;
         pa_q    <= 14'h0;
         ce_q    <= 1'b1;
         rw_q    <= 1'b1;
         oe_q    <= 1'b1;
         ub_q    <= 1'b1;
         lb_q    <= 1'b1;
         sem_q   <= 1'b1;
         dq_q    <= 16'h0;
         doe_q   <= 2'b11;
      end else begin
         state_q <= state_d;
         op_q    <= op_d;
         cnt_q   <= cnt_d;
         rdata_q <= rdata_d;
         done_q  <= done_d;
         stall_q <= stall_d;
         pa_q    <= pa_d;
         ce_q    <= ce_d;
         rw_q    <= rw_d;
         oe_q    <= oe_d;
         ub_q    <= ub_d;
         lb_q    <= lb_d;
         sem_q   <= sem_d;
         dq_q    <= dq_d;
         doe_q   <= doe_d;
      end
   end

   // Pins come straight from their registers
   assign avs_readdata     = rd_q;
   assign avs_waitrequest  = wait_q;
   assign mem_addr         = pa_q;
   assign chip_sel_n       = ce_q;
   assign read_write       = rw_q;
   assign out_en_n         = oe_q;
   assign upper_lane_sel_n = ub_q;
   assign lower_lane_sel_n = lb_q;
   assign flag_space_sel_n = sem_q;
   assign data_o           = dq_q;
   assign data_oe_n        = doe_q;

endmodule

`default_nettype wire

// ---- test/dpram_port_host_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dpram_host_cfg.svh"
module dpram_port_host_asserts (
   input wire logic               ref_clk,
   input wire logic               resetn,
   input wire logic [`ADDR_W-1:0] mem_addr,
   input wire logic               chip_sel_n,
   input wire logic               read_write,
   input wire logic               out_en_n,
   input wire logic               upper_lane_sel_n,
   input wire logic               lower_lane_sel_n,
   input wire logic               flag_space_sel_n,
   input wire logic [1:0]         data_oe_n,
   input wire logic               busy_n
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_read_rw_high: assert property (!out_en_n |-> read_write)
      else $error("read cycle with rw low");
   a_addr_before_sel: assert property ($fell(chip_sel_n) |-> $stable(mem_addr))
      else $error("address moved as select fell");
   a_addr_rw_high: assert property ($changed(mem_addr) |-> read_write && $past(read_write))
      else $error("address moved with rw low");
   a_no_drive_read: assert property (!out_en_n |-> data_oe_n == 2'b11)
      else $error("data driven during read");
   a_flag_ce_high: assert property (!flag_space_sel_n |-> chip_sel_n)
      else $error("flag access with select low");
   a_lane_on_ce: assert property (!chip_sel_n |-> !(upper_lane_sel_n && lower_lane_sel_n))
      else $error("select low with no lane");
   a_sel_ends_first: assert property ($rose(read_write) |-> chip_sel_n && flag_space_sel_n)
      else $error("rw rose before select");
   a_drive_in_write: assert property (data_oe_n != 2'b11 |-> !read_write)
      else $error("data driven with rw high");
   cover property (!chip_sel_n && !read_write);
   cover property (!flag_space_sel_n && !out_en_n);
   cover property (!busy_n && !chip_sel_n);
endmodule
bind dpram_port_host dpram_port_host_asserts u_dpram_port_host_asserts (.ref_clk, .resetn,
   .mem_addr, .chip_sel_n, .read_write, .out_en_n, .upper_lane_sel_n, .lower_lane_sel_n,
   .flag_space_sel_n, .data_oe_n, .busy_n);
`default_nettype wire

// ---- test/dpram_port_model.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dpram_host_cfg.svh"
module dpram_port_model (
   input  wire logic [`ADDR_W-1:0] mem_addr,
   input  wire logic               chip_sel_n,
   input  wire logic               read_write,
   input  wire logic               out_en_n,
   input  wire logic               upper_lane_sel_n,
   input  wire logic               lower_lane_sel_n,
   input  wire logic               flag_space_sel_n,
   input  wire logic [`DATA_W-1:0] data_o,
   input  wire logic [1:0]         data_oe_n,
   input  wire logic               contend,
   output logic      [`DATA_W-1:0] data_i,
   output logic                    busy_n
);
   logic [`DATA_W-1:0] mem [0:(1<<`ADDR_W)-1];
   logic               flag = 1'b1;
   logic [1:0]         lanes_q;
   logic [`DATA_W-1:0] dev;
   logic [1:0]         drv;
   logic               ram_we, sem_we, ram_rd, sem_rd;
   initial foreach (mem[i]) mem[i] = '0;
   // Other port sits on the same word
   assign busy_n = !(contend && !chip_sel_n);
   // Gated by contend, not busy_n, so no zero-time write glitch
   assign ram_we = !chip_sel_n && !read_write && flag_space_sel_n && !contend
                   && !(upper_lane_sel_n && lower_lane_sel_n);
   assign sem_we = chip_sel_n && !flag_space_sel_n && !read_write;
   assign ram_rd = !chip_sel_n && read_write && !out_en_n && flag_space_sel_n;
   assign sem_rd = chip_sel_n && !flag_space_sel_n && read_write && !out_en_n;
   assign dev = sem_rd ? {`DATA_W{flag}} : mem[mem_addr];
   assign drv[1] = sem_rd || ram_rd && !upper_lane_sel_n;
   assign drv[0] = sem_rd || ram_rd && !lower_lane_sel_n;
   // Undriven lanes show inverted data so stale values never pass
   assign data_i[15:8] = !data_oe_n[1] ? data_o[15:8] : drv[1] ? dev[15:8] : ~dev[15:8];
   assign data_i[7:0] = !data_oe_n[0] ? data_o[7:0] : drv[0] ? dev[7:0] : ~dev[7:0];
   always @(posedge ram_we) lanes_q = {upper_lane_sel_n, lower_lane_sel_n};
   always @(negedge ram_we) begin
      if (!lanes_q[1]) mem[mem_addr][15:8] = data_i[15:8];
      if (!lanes_q[0]) mem[mem_addr][7:0] = data_i[7:0];
   end
   always @(negedge sem_we) if (read_write === 1'b0) flag = data_i[0];
endmodule
`default_nettype wire

// ---- test/tb_dpram_port_host.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "dpram_host_cfg.svh"
module tb_dpram_port_host
   import dpram_host_pkg::*;
;
   logic               ref_clk, resetn, avs_read, avs_write, avs_waitrequest, contend;
   logic [2:0]         avs_address;
   logic [31:0]        avs_writedata, avs_readdata, q, st;
   logic               chip_sel_n, read_write, out_en_n, busy_n;
   logic               upper_lane_sel_n, lower_lane_sel_n, flag_space_sel_n;
   logic [`ADDR_W-1:0] mem_addr;
   logic [`DATA_W-1:0] data_i, data_o;
   logic [1:0]         data_oe_n;
   int                 errors = 0, check_count = 0;
   dpram_port_host u_dpram_port_host (.ref_clk, .resetn, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .mem_addr, .chip_sel_n, .read_write,
      .out_en_n, .upper_lane_sel_n, .lower_lane_sel_n, .flag_space_sel_n, .data_i, .data_o,
      .data_oe_n, .busy_n);
   dpram_port_model u_dpram_port_model (.mem_addr, .chip_sel_n, .read_write, .out_en_n,
      .upper_lane_sel_n, .lower_lane_sel_n, .flag_space_sel_n, .data_o, .data_oe_n, .contend,
      .data_i, .busy_n);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic av(input logic [2:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      if (n >= 100) errors++;
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic op(input port_op_t o, input logic up, input logic lo,
                     input logic [13:0] a, input logic [15:0] d);
      int n;
      n = 0;
      av(`REG_ADDR, 1'b1, {18'h0, a}, q);
      av(`REG_WDATA, 1'b1, {16'h0, d}, q);
      av(`REG_CTRL, 1'b1, {27'h0, lo, up, o, 1'b1}, q);
      do begin
         av(`REG_STATUS, 1'b0, 32'h0, st);
         n++;
      end while (st[1] !== 1'b1 && n < 100);
      av(`REG_RDATA, 1'b0, 32'h0, q);
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #400000;
      errors++;
      end_of_test();
   end
   initial begin
      resetn = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 3'h0;
      avs_writedata = 32'h0;
      contend = 1'b0;
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      av(`REG_CTRL, 1'b0, 32'h0, q);
      chk(q, 32'h18);
      av(3'h7, 1'b0, 32'h0, q);
      chk(q, 32'h0);
      op(OP_SEM_RD, 1'b1, 1'b1, 14'h0, 16'h0);
      chk(q, 32'h1);
      op(OP_RAM_WR, 1'b1, 1'b1, 14'h3fff, 16'hbeef);
      chk(st, 32'h2);
      op(OP_RAM_RD, 1'b1, 1'b1, 14'h3fff, 16'h0);
      chk(q, 32'hbeef);
      op(OP_RAM_WR, 1'b1, 1'b0, 14'h3fff, 16'h55aa);
      op(OP_RAM_RD, 1'b1, 1'b1, 14'h3fff, 16'h0);
      chk(q, 32'h55ef);
      op(OP_RAM_RD, 1'b0, 1'b1, 14'h3fff, 16'h0);
      chk({24'h0, q[7:0]}, 32'hef);
      op(OP_RAM_RD, 1'b0, 1'b0, 14'h3fff, 16'h0);
      chk(st, 32'h2);
      for (int i = 0; i < 2; i++) begin
         op(OP_SEM_WR, 1'b1, 1'b1, 14'h0, {15'h0, i[0]});
         op(OP_SEM_RD, 1'b1, 1'b1, 14'h0, 16'h0);
         chk(q, {31'h0, i[0]});
      end
      contend <= 1'b1;
      fork
         op(OP_RAM_WR, 1'b1, 1'b1, 14'h1, 16'h1357);
         begin
            repeat (16) @(posedge ref_clk);
            contend <= 1'b0;
         end
      join
      chk(st, 32'h6);
      op(OP_RAM_RD, 1'b1, 1'b1, 14'h1, 16'h0);
      chk(q, 32'h1357);
      end_of_test();
   end
endmodule
`default_nettype wire
